// [verilog/uefr_pkg.sv]
package uefr_pkg;

    localparam logic [7:0] ADDR_FRAME_NUMBER_LOW = 8'hBA;
    localparam logic [7:0] ADDR_FRAME_NUMBER_HIGH_CRC = 8'hBB;
    localparam logic [7:0] ADDR_ENDPOINT_IRQ_ENABLE = 8'hC2;
    localparam logic [7:0] ADDR_ENDPOINT_FIFO_PORT = 8'hCF;
    localparam logic [7:0] ADDR_ENDPOINT_BYTE_COUNT = 8'hE2;
    localparam logic [7:0] ADDR_USB_CLOCK_DIVIDER = 8'hEA;
    localparam logic [7:0] ADDR_ENDPOINT_IRQ_FLAGS = 8'hF8;

    localparam int NUM_ENDPOINTS = 4;
    localparam int FIFO_DEPTH = 64;
    localparam int FIFO_PTR_W = 6;
    localparam int BYTE_COUNT_W = 7;
    localparam int FRAME_W = 11;

    localparam int FRAME_CHECK_GOOD_BIT = 5;
    localparam int FRAME_CHECK_BAD_BIT = 4;
    localparam int FRAME_UPPER_MSB = 2;

    localparam logic [3:0] RESET_IRQ_ENABLE = 4'h0;
    localparam logic [3:0] RESET_IRQ_FLAGS = 4'h0;
    localparam logic [10:0] RESET_FRAME_NUMBER = 11'h000;
    localparam logic [6:0] RESET_BYTE_COUNT = 7'h00;
    localparam logic [1:0] RESET_CLOCK_RATIO = 2'h0;

    // Special-function register access from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } uefr_sfr_req_t;

    // Start-of-frame report from the packet engine
    typedef struct packed {
        logic pid_seen;
        logic done;
        logic crc_good;
        logic [10:0] number;
    } uefr_sof_t;

    // Received OUT data from the packet engine
    typedef struct packed {
        logic data_pid;
        logic byte_valid;
        logic [7:0] data;
        logic packet_end;
        logic [1:0] endpoint;
    } uefr_rx_t;

endpackage

// [verilog/uefr_fifo_bank.sv]
`timescale 1ns/1ps
// Per-endpoint byte storage shared by the packet engine and the core port
module uefr_fifo_bank (
    input wire logic clk,                      // Core clock
    input wire logic reset_n,                  // Async reset, active low
    input wire logic [1:0] sel,                // Endpoint picked by firmware
    input wire logic cpu_wr,                   // Core writes the data port
    input wire logic cpu_rd,                   // Core reads the data port
    input wire logic [7:0] cpu_wdata,          // Byte from the core
    output logic [7:0] cpu_rdata,              // Byte at selected pointer
    input wire logic eng_wr,                   // Engine stores a received byte
    input wire logic eng_start,                // Engine starts a new packet
    input wire logic [1:0] eng_ep,             // Endpoint the engine targets
    input wire logic [7:0] eng_wdata           // Received byte
);

    logic [7:0] mem [uefr_pkg::NUM_ENDPOINTS][uefr_pkg::FIFO_DEPTH];
    logic [uefr_pkg::FIFO_PTR_W-1:0] cpu_ptr [uefr_pkg::NUM_ENDPOINTS];
    logic [uefr_pkg::FIFO_PTR_W-1:0] eng_ptr [uefr_pkg::NUM_ENDPOINTS];

    // Engine byte lands in eng_ep's memory, core byte in sel's memory; engine wins a clash
    always_ff @(posedge clk) begin
        if (eng_wr) begin
            mem[eng_ep][eng_ptr[eng_ep]] <= eng_wdata;
        end else if (cpu_wr) begin
            mem[sel][cpu_ptr[sel]] <= cpu_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < uefr_pkg::NUM_ENDPOINTS; i++) begin
                cpu_ptr[i] <= '0;
            end
        end else begin
            if (eng_start) begin
                cpu_ptr[eng_ep] <= '0;
            end
            if ((cpu_wr || cpu_rd) && !(eng_start && eng_ep == sel)) begin
                cpu_ptr[sel] <= cpu_ptr[sel] + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < uefr_pkg::NUM_ENDPOINTS; i++) begin
                eng_ptr[i] <= '0;
            end
        end else if (eng_start) begin
            eng_ptr[eng_ep] <= '0;
        end else if (eng_wr) begin
            eng_ptr[eng_ep] <= eng_ptr[eng_ep] + 1'b1;
        end
    end

    // Left combinational so the register block can capture it on the read edge
    assign cpu_rdata = mem[sel][cpu_ptr[sel]];

endmodule

// [verilog/uefr_regs.sv]
`timescale 1ns/1ps
module uefr_regs (
    input wire logic clk,                              // Core clock, 250 MHz
    input wire logic reset_n,                          // Async reset, active low
    input wire uefr_pkg::uefr_sfr_req_t sfr_req,       // Register access
    output logic [7:0] sfr_rdata,                      // Read data, next cycle
    input wire logic [1:0] endpoint_select,            // From endpoint select reg
    input wire logic [3:0] endpoint_status_event,      // Status flag rise per EP
    input wire uefr_pkg::uefr_sof_t sof,               // Start-of-frame report
    input wire uefr_pkg::uefr_rx_t rx,                 // Received OUT data
    output logic [3:0] endpoint_irq_flags,             // Sticky endpoint flags
    output logic sof_irq,                              // Start-of-frame pulse
    output logic [1:0] controller_clock_ratio,         // Divider select
    output logic [10:0] frame_number                   // Last good frame number
);

    logic [3:0] endpoint_irq_enable;
    logic frame_check_good;
    logic frame_check_bad;
    logic [6:0] byte_count [uefr_pkg::NUM_ENDPOINTS];
    logic [6:0] rx_run;
    logic [7:0] fifo_rdata;
    logic [7:0] next_rdata;
    logic fifo_wr;
    logic fifo_rd;
    logic [3:0] flag_write;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic hit(input uefr_pkg::uefr_sfr_req_t r, input logic [7:0] a);
        return r.addr == a;
    endfunction

    assign fifo_wr = sfr_req.wr && hit(sfr_req, uefr_pkg::ADDR_ENDPOINT_FIFO_PORT);
    assign fifo_rd = sfr_req.rd && hit(sfr_req, uefr_pkg::ADDR_ENDPOINT_FIFO_PORT);

    ////////////////////////////////////////////////////////////////////////
    // Enable register; upper bits are not stored
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            endpoint_irq_enable <= uefr_pkg::RESET_IRQ_ENABLE;
        end else if (sfr_req.wr && hit(sfr_req, uefr_pkg::ADDR_ENDPOINT_IRQ_ENABLE)) begin
            endpoint_irq_enable <= sfr_req.wdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            controller_clock_ratio <= uefr_pkg::RESET_CLOCK_RATIO;
        end else if (sfr_req.wr && hit(sfr_req, uefr_pkg::ADDR_USB_CLOCK_DIVIDER)) begin
            controller_clock_ratio <= sfr_req.wdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags: firmware can only clear (write 0 to a bit); a new enabled event wins
    always_comb begin
        flag_write = endpoint_irq_flags;
        if (sfr_req.wr && hit(sfr_req, uefr_pkg::ADDR_ENDPOINT_IRQ_FLAGS)) begin
            flag_write = endpoint_irq_flags & sfr_req.wdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            endpoint_irq_flags <= uefr_pkg::RESET_IRQ_FLAGS;
        end else begin
            endpoint_irq_flags <= flag_write
                | (endpoint_status_event & endpoint_irq_enable);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start of frame: interrupt on the PID, number and CRC bits at the end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sof_irq <= 1'b0;
        end else begin
            sof_irq <= sof.pid_seen;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_number <= uefr_pkg::RESET_FRAME_NUMBER;
        end else if (sof.done && sof.crc_good) begin
            frame_number <= sof.number;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_check_good <= 1'b0;
            frame_check_bad <= 1'b0;
        end else if (sof.done) begin
            frame_check_good <= sof.crc_good;
            frame_check_bad <= !sof.crc_good;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte count: counts data bytes after the data PID, saved at packet end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_run <= uefr_pkg::RESET_BYTE_COUNT;
        end else if (rx.data_pid) begin
            rx_run <= uefr_pkg::RESET_BYTE_COUNT;
        end else if (rx.byte_valid) begin
            rx_run <= rx_run + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < uefr_pkg::NUM_ENDPOINTS; i++) begin
                byte_count[i] <= uefr_pkg::RESET_BYTE_COUNT;
            end
        end else if (rx.packet_end) begin
            byte_count[rx.endpoint] <= rx_run;
        end
    end

    uefr_fifo_bank fifo (
        .clk(clk),
        .reset_n(reset_n),
        .sel(endpoint_select),
        .cpu_wr(fifo_wr),
        .cpu_rd(fifo_rd),
        .cpu_wdata(sfr_req.wdata),
        .cpu_rdata(fifo_rdata),
        .eng_wr(rx.byte_valid),
        .eng_start(rx.data_pid),
        .eng_ep(rx.endpoint),
        .eng_wdata(rx.data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read mux; every answer is registered, so it stands until the next read
    always_comb begin
        next_rdata = 8'h00;
        if (hit(sfr_req, uefr_pkg::ADDR_ENDPOINT_FIFO_PORT)) begin
            next_rdata = fifo_rdata;
        end else if (hit(sfr_req, uefr_pkg::ADDR_FRAME_NUMBER_LOW)) begin
            next_rdata = frame_number[7:0];
        end else if (hit(sfr_req, uefr_pkg::ADDR_FRAME_NUMBER_HIGH_CRC)) begin
            next_rdata = {2'h0, frame_check_good, frame_check_bad, 1'b0,
                frame_number[10:8]};
        end else if (hit(sfr_req, uefr_pkg::ADDR_ENDPOINT_IRQ_ENABLE)) begin
            next_rdata = {4'h0, endpoint_irq_enable};
        end else if (hit(sfr_req, uefr_pkg::ADDR_ENDPOINT_BYTE_COUNT)) begin
            next_rdata = {1'b0, byte_count[endpoint_select]};
        end else if (hit(sfr_req, uefr_pkg::ADDR_USB_CLOCK_DIVIDER)) begin
            next_rdata = {6'h00, controller_clock_ratio};
        end else if (hit(sfr_req, uefr_pkg::ADDR_ENDPOINT_IRQ_FLAGS)) begin
            next_rdata = {4'h0, endpoint_irq_flags};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_req.rd) begin
            sfr_rdata <= next_rdata;
        end
    end

endmodule

// [tb/uefr_engine_model.sv]
`timescale 1ns/1ps
// Packet engine stand-in: frame reports and received OUT data
module uefr_engine_model (
    input wire logic clk, // Core clock
    output uefr_pkg::uefr_sof_t sof, // Frame report
    output uefr_pkg::uefr_rx_t rx // Received data
);
    initial begin
        sof = '0;
        rx = '0;
    end
    ////////////////////////////////////////
    // Number is scrambled outside the report so stale values cannot pass
    task automatic send_sof(input logic [10:0] n, input logic ok, input int gap);
        @(posedge clk);
        sof.pid_seen <= 1'h1;
        @(posedge clk);
        sof.pid_seen <= 1'h0;
        repeat (gap) @(posedge clk);
        sof.done <= 1'h1;
        sof.crc_good <= ok;
        sof.number <= n;
        @(posedge clk);
        sof.done <= 1'h0;
        sof.number <= ~n;
    endtask
    task automatic send_pkt(input logic [1:0] ep, input int len, input logic [7:0] base,
        input logic slow);
        @(posedge clk);
        rx.endpoint <= ep;
        rx.data_pid <= 1'h1;
        @(posedge clk);
        rx.data_pid <= 1'h0;
        for (int i = 0; i < len; i++) begin
            rx.byte_valid <= 1'h1;
            rx.data <= base + 8'(i);
            @(posedge clk);
            if (slow) begin
                rx.byte_valid <= 1'h0;
                rx.data <= ~rx.data;
                @(posedge clk);
            end
        end
        rx.byte_valid <= 1'h0;
        rx.data <= rx.data + 8'h81;
        rx.packet_end <= 1'h1;
        @(posedge clk);
        rx.packet_end <= 1'h0;
    endtask
endmodule

// [tb/uefr_regs_checker.sv]
`timescale 1ns/1ps
module uefr_regs_checker (
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset
    input wire uefr_pkg::uefr_sfr_req_t sfr_req, // Access
    input wire logic [7:0] sfr_rdata, // Read data
    input wire logic [3:0] endpoint_status_event, // Events
    input wire uefr_pkg::uefr_sof_t sof, // Frame report
    input wire logic [3:0] endpoint_irq_flags, // Flags
    input wire logic sof_irq, // Frame pulse
    input wire logic [1:0] controller_clock_ratio, // Ratio
    input wire logic [10:0] frame_number // Frame
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [3:0] en;
    logic [3:0] ev;
    logic [3:0] fl;
    assign ev = endpoint_status_event & en;
    assign fl = endpoint_irq_flags;
    // Shadow of the enable register, tracked from the write traffic
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            en <= 4'h0;
        else if (sfr_req.wr && sfr_req.addr == 8'hC2)
            en <= sfr_req.wdata[3:0];
    end
    sequence sof_pid_s;
        sof.pid_seen;
    endsequence
    ////////////////////////////////////////
    flag_set_a:
    assert property (ev != 4'h0 |=> (fl & $past(ev)) == $past(ev)) else $error("flag not set");
    flag_mask_a:
    assert property (1'h1 |=> (fl & ~$past(fl) & ~$past(ev)) == 4'h0) else $error("flag rose");
    flag_keep_a:
    assert property (!(sfr_req.wr && sfr_req.addr == 8'hF8) |=> (fl & $past(fl)) == $past(fl))
        else $error("flag cleared by itself");
    sof_pulse_a:
    assert property (sof_pid_s |=> sof_irq) else $error("no frame pulse");
    sof_only_a:
    assert property (sof_irq |-> $past(sof.pid_seen)) else $error("stray frame pulse");
    frame_good_a:
    assert property (sof.done && sof.crc_good |=> frame_number == $past(sof.number))
        else $error("frame not taken");
    frame_keep_a:
    assert property (sof.done && !sof.crc_good |=> $stable(frame_number))
        else $error("bad frame taken");
    ratio_out_a:
    assert property (sfr_req.wr && sfr_req.addr == 8'hEA
        |=> controller_clock_ratio == $past(sfr_req.wdata[1:0])) else $error("ratio wrong");
    reserved_zero_a:
    assert property (sfr_req.rd && sfr_req.addr inside {8'hF8, 8'hC2, 8'hEA}
        |=> sfr_rdata[7:4] == 4'h0) else $error("reserved bits set");
    high_reserved_a:
    assert property (sfr_req.rd && sfr_req.addr == 8'hBB
        |=> sfr_rdata[7:6] == 2'h0 && !sfr_rdata[3]) else $error("high reserved bits set");
    crc_pair_a:
    assert property (sfr_req.rd && sfr_req.addr == 8'hBB
        |=> !(sfr_rdata[5] && sfr_rdata[4])) else $error("both check bits set");
    count_top_a:
    assert property (sfr_req.rd && sfr_req.addr == 8'hE2 |=> !sfr_rdata[7])
        else $error("count bit 7 set");
    rdata_hold_a:
    assert property (!sfr_req.rd |=> $stable(sfr_rdata)) else $error("read data moved");
endmodule
bind uefr_regs uefr_regs_checker u_chk (.clk, .reset_n, .sfr_req, .sfr_rdata,
    .endpoint_status_event, .sof, .endpoint_irq_flags, .sof_irq, .controller_clock_ratio,
    .frame_number);

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic clk;
    logic reset_n;
    uefr_pkg::uefr_sfr_req_t sfr_req;
    logic [7:0] sfr_rdata;
    logic [1:0] endpoint_select;
    logic [3:0] endpoint_status_event;
    uefr_pkg::uefr_sof_t sof;
    uefr_pkg::uefr_rx_t rx;
    logic [3:0] endpoint_irq_flags;
    logic sof_irq;
    logic [1:0] controller_clock_ratio;
    logic [10:0] frame_number;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [7:0] d;
    logic [3:0] en, evx, keep, exp_flags;
    logic [10:0] n, last;
    logic ok;
    logic [6:0] len [4];
    logic [7:0] base [4];
    logic [7:0] addrs [6] = '{8'hBA, 8'hBB, 8'hC2, 8'hE2, 8'hF8, 8'h10};
    uefr_regs u_uefr_regs (.clk, .reset_n, .sfr_req, .sfr_rdata, .endpoint_select,
        .endpoint_status_event, .sof, .rx, .endpoint_irq_flags, .sof_irq,
        .controller_clock_ratio, .frame_number);
    uefr_engine_model u_uefr_engine_model (.clk, .sof, .rx);
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////
    function automatic logic [7:0] high_exp(input logic [10:0] f, input logic g);
        return {2'h0, g, !g, 1'h0, f[10:8]};
    endfunction
    task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sfr_req.wr <= 1'h1;
        sfr_req.addr <= a;
        sfr_req.wdata <= v;
        @(posedge clk);
        sfr_req.wr <= 1'h0;
    endtask
    // Read data lands on the edge after the request; sample once it has settled
    task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string m);
        @(posedge clk);
        sfr_req.rd <= 1'h1;
        sfr_req.addr <= a;
        @(posedge clk);
        sfr_req.rd <= 1'h0;
        #1;
        d = sfr_rdata;
        chk(11'(d), 11'(exp), m);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    ////////////////////////////////////////
    initial begin
        reset_n = 1'h0;
        sfr_req = '0;
        endpoint_select = 2'h0;
        endpoint_status_event = 4'h0;
        void'($urandom(62));
        repeat (5) @(posedge clk);
        reset_n <= 1'h1;
        foreach (addrs[i]) rc(addrs[i], 8'h00, "reset value");
        $display("test reset done");
        for (int r = 0; r < 4; r++) begin
            wr(8'hEA, 8'(r));
            rc(8'hEA, 8'(r), "divider readback");
            chk(11'(controller_clock_ratio), 11'(r), "divider output");
        end
        $display("test divider done");
        // First two rounds: all masked, then all enabled, every endpoint firing
        exp_flags = 4'h0;
        for (int k = 0; k < 8; k++) begin
            en = (k < 2) ? {4{k[0]}} : 4'($urandom);
            evx = (k < 2) ? 4'hF : 4'($urandom);
            wr(8'hC2, {4'h0, en});
            rc(8'hC2, {4'h0, en}, "enable readback");
            @(posedge clk);
            endpoint_status_event <= evx;
            @(posedge clk);
            endpoint_status_event <= 4'h0;
            exp_flags = exp_flags | (en & evx);
            rc(8'hF8, {4'h0, exp_flags}, "flag set");
            if (k[0]) begin
                keep = 4'($urandom);
                wr(8'hF8, {4'h0, keep});
                exp_flags = exp_flags & keep;
                rc(8'hF8, {4'h0, exp_flags}, "flag clear");
            end
        end
        chk(11'(endpoint_irq_flags), 11'(exp_flags), "flag port");
        // Clear and a new event on one edge: the event must win
        wr(8'hC2, 8'h0F);
        @(posedge clk);
        sfr_req.wr <= 1'h1;
        sfr_req.addr <= 8'hF8;
        sfr_req.wdata <= 8'h00;
        endpoint_status_event <= 4'h5;
        @(posedge clk);
        sfr_req.wr <= 1'h0;
        endpoint_status_event <= 4'h0;
        rc(8'hF8, 8'h05, "set beats clear");
        $display("test flags done");
        last = 11'h000;
        for (int k = 0; k < 6; k++) begin
            ok = (k % 3 != 1);
            n = (k == 0) ? 11'h7FF : 11'($urandom);
            u_uefr_engine_model.send_sof(n, ok, k);
            if (ok)
                last = n;
            rc(8'hBA, last[7:0], "frame low");
            rc(8'hBB, high_exp(last, ok), "frame high");
            chk(frame_number, last, "frame port");
        end
        $display("test frame done");
        for (int e = 0; e < 4; e++) begin
            len[e] = (e == 3) ? 7'h3F : 7'(1 + $urandom % 20);
            base[e] = 8'($urandom);
            u_uefr_engine_model.send_pkt(2'(e), int'(len[e]), base[e], e[0]);
        end
        for (int e = 0; e < 4; e++) begin
            @(posedge clk);
            endpoint_select <= 2'(e);
            rc(8'hE2, {1'h0, len[e]}, "byte count");
            for (int i = 0; i < len[e]; i++)
                rc(8'hCF, base[e] + 8'(i), "fifo byte");
        end
        $display("test fifo done");
        // Firmware fills endpoint 2 through the port; an empty packet rewinds it
        u_uefr_engine_model.send_pkt(2'h2, 0, 8'h00, 1'h0);
        endpoint_select <= 2'h2;
        for (int i = 0; i < 4; i++)
            wr(8'hCF, base[0] ^ 8'(i));
        u_uefr_engine_model.send_pkt(2'h2, 0, 8'h00, 1'h0);
        rc(8'hE2, 8'h00, "empty packet count");
        for (int i = 0; i < 4; i++)
            rc(8'hCF, base[0] ^ 8'(i), "port write");
        $display("test port write done");
        end_of_test();
    end
endmodule
